// ===== quad_lerp.sv
`timescale 1ns/100ps
module quad_lerp #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Request: a + (b - a) * n / d
	input wire logic i_start,
	input wire logic [W-1:0] i_a,
	input wire logic [W-1:0] i_b,
	input wire logic [W-1:0] i_n,
	input wire logic [W-1:0] i_d,
	// Result
	output logic o_done,
	output logic [W-1:0] o_res
);
	import quad_pkg::*;

	localparam int PW = 2 * W + 2;

	typedef struct packed {
		logic busy;
		logic neg;
		logic [PW-1:0] m;
		logic [W:0] r;
		logic [7:0] cnt;
		logic [W-1:0] a;
		logic [W-1:0] d;
		logic done;
		logic [W-1:0] res;
	} lerp_s;

	lerp_s q, n;
	logic signed [W:0] diff;
	logic signed [PW-1:0] prod;
	logic [PW-1:0] mag;
	logic [W:0] r2;
	logic ge;

	if (W < 2 || PW > 255) begin : g_chk
		$error("quad_lerp: W out of range");
	end

	assign diff = $signed({i_b[W-1], i_b}) - $signed({i_a[W-1], i_a});
	assign prod = PW'(diff) * PW'($signed({1'b0, i_n}));
	assign mag = prod[PW-1] ? PW'(-prod) : prod;
	assign r2 = {q.r[W-1:0], q.m[PW-1]};
	assign ge = r2 >= {1'b0, q.d};

	// Restoring division, one quotient bit per clock
	always_comb begin
		n = q;
		n.done = 1'b0;
		if (i_start) begin
			n.neg = prod[PW-1];
			n.m = mag;
			n.r = '0;
			n.cnt = 8'(PW);
			n.a = i_a;
			n.d = i_d;
			n.busy = (i_d != '0);
			n.done = (i_d == '0);
			n.res = i_a;
		end else if (q.busy && q.cnt != 8'h00) begin
			n.r = ge ? r2 - {1'b0, q.d} : r2;
			n.m = {q.m[PW-2:0], ge};
			n.cnt = q.cnt - 8'h01;
		end else if (q.busy) begin
			n.busy = 1'b0;
			n.done = 1'b1;
			n.res = q.neg ? q.a - q.m[W-1:0] : q.a + q.m[W-1:0];
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign o_done = q.done;
	assign o_res = q.res;
endmodule

// ===== quad_list_engine.sv
`timescale 1ns/100ps
module quad_list_engine #(
	parameter int AW = 24
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Register bus
	input wire logic [quad_pkg::RA_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// List and source memory read
	output logic o_mem_rd,
	output logic [AW-1:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic [15:0] i_mem_rdata,
	// Work plane read at pixel coordinates
	output logic o_wk_rd,
	input wire logic i_wk_ack,
	input wire logic i_wk_bit,
	// Pixel write
	output logic o_pix_wr,
	output logic [15:0] o_pix_x,
	output logic [15:0] o_pix_y,
	output logic [63:0] o_pix_data,
	output logic o_pix_quad,
	output logic o_pix_clipping_sel,
	input wire logic i_pix_ack,
	// Controller side
	input wire logic i_frame_tick,
	output logic o_busy,
	output logic o_list_done,
	output logic o_regw_en,
	output logic [15:0] o_regw_addr,
	output logic [15:0] o_regw_data,
	output logic o_work_clr
);
	import quad_pkg::*;

	typedef struct packed {
		state_e st;
		logic [1:0] ph;
		logic go;
		logic [AW-1:0] pc;
		logic [AW-1:0] cpc;
		logic [AW-1:0] rpc;
		logic [AW-1:0] lbase;
		logic [AW-1:0] sbase;
		logic [AW-1:0] base;
		logic [15:0] cmd;
		logic [NARG-1:0][15:0] arg;
		logic [3:0] ac;
		logic [15:0] stride;
		logic [15:0] du;
		logic [15:0] dv;
		logic [15:0] su;
		logic [15:0] sv;
		logic [1:0] k;
		logic [15:0] lx;
		logic [15:0] ly;
		logic [15:0] rx;
		logic [15:0] ry;
		logic [15:0] px;
		logic [15:0] py;
		logic [63:0] pix;
		logic mrd;
		logic [AW-1:0] maddr;
		logic pwr;
		logic wrd;
		logic rw;
		logic [15:0] rwa;
		logic [15:0] rwd;
		logic wclr;
		logic ldone;
		logic [15:0] color;
		logic [15:0] pitch;
		logic pix16;
		logic busy;
		logic sdone;
		logic serr;
		logic aw;
		logic [31:0] ard;
	} eng_s;

	eng_s q, n;

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------
	logic [4:0] op;
	logic fast_quad_sel, direct;
	logic [31:0] lin, sidx, soff, poff, poffb, wd;
	logic [AW-1:0] ltgt, saddr;
	logic [15:0] cols, rows, step, du_n, su_n, dv_n, sv_n, lane, sat_sum;
	logic [15:0] la_x, lb_x, la_y, lb_y, l_n, l_d, res_x, res_y;
	logic done_x;

	if (AW < 16 || AW > 32) begin : g_chk
		$error("quad_list_engine: AW must be 16 to 32");
	end

	assign op = q.cmd[CODE_LSB +: CODE_W];
	assign fast_quad_sel = q.cmd[F_FST];
	assign direct = q.cmd[F_REPEAT_SOURCE_SEL] | fast_quad_sel;
	assign lin = {q.arg[A_HI], q.arg[A_LO]};
	assign ltgt = q.cmd[F_REL] ? q.cpc + lin[AW-1:0] : lin[AW-1:0];
	assign poff = q.arg[A_SY] * q.pitch + {16'h0000, q.arg[A_SX]};
	assign poffb = q.pix16 ? {poff[30:0], 1'b0} : poff;
	assign cols = direct ? q.arg[A_VX2] - q.arg[A_VX1] + STEP_ONE : q.arg[A_W];
	assign rows = direct ? q.arg[A_VY4] - q.arg[A_VY1] + STEP_ONE : q.arg[A_H];
	assign step = fast_quad_sel ? STEP_FAST : STEP_ONE;
	assign du_n = q.du + step;
	assign su_n = q.su + step;
	assign dv_n = q.dv + STEP_ONE;
	assign sv_n = q.sv + STEP_ONE;
	// Stride of the source rows: width when linear, pitch otherwise
	assign sidx = q.sv * q.stride + {16'h0000, q.su} + {30'h0, q.k};
	assign soff = q.pix16 ? {sidx[30:0], 1'b0} : sidx;
	assign saddr = q.base + soff[AW-1:0];
	assign wd = i_avs_writedata;

	// 8 bpp pixels sit in the low lane; offset only applies at 16 bpp
	always_comb begin
		if (!q.pix16) begin
			lane = {8'h00, saddr[0] ? i_mem_rdata[15:8] : i_mem_rdata[7:0]};
		end else if (q.cmd[F_COLOR_OFFSET_SEL]) begin
			lane = sat_sum;
		end else begin
			lane = i_mem_rdata;
		end
	end

	// Edge and point interpolation operands
	always_comb begin
		l_n = q.dv;
		l_d = q.arg[A_H] - STEP_ONE;
		case (q.ph)
		PH_LEFT: begin
			la_x = q.arg[A_VX1];
			lb_x = q.arg[A_VX4];
			la_y = q.arg[A_VY1];
			lb_y = q.arg[A_VY4];
		end
		PH_RIGHT: begin
			la_x = q.arg[A_VX2];
			lb_x = q.arg[A_VX3];
			la_y = q.arg[A_VY2];
			lb_y = q.arg[A_VY3];
		end
		default: begin
			la_x = q.lx;
			lb_x = q.rx;
			la_y = q.ly;
			lb_y = q.ry;
			l_n = q.su;
			l_d = q.arg[A_W] - STEP_ONE;
		end
		endcase
	end

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				o[i*8 +: 8] = v[i*8 +: 8];
			end
		end
		merge = o;
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		n = q;
		n.go = 1'b0;
		n.rw = 1'b0;
		n.wclr = 1'b0;
		n.ldone = 1'b0;
		// One wait cycle per access; data stands when waitrequest drops
		n.aw = 1'b1;
		if ((i_avs_read || i_avs_write) && q.aw) begin
			n.aw = 1'b0;
			case (i_avs_address)
			R_CTRL: n.ard = 32'({q.pix16, 1'b0});
			R_STATUS: n.ard = 32'({q.serr, q.sdone, q.busy});
			R_LBASE: n.ard = 32'(q.lbase);
			R_SBASE: n.ard = 32'(q.sbase);
			R_PITCH: n.ard = 32'(q.pitch);
			R_COLOR: n.ard = 32'(q.color);
			R_PC: n.ard = 32'(q.pc);
			default: n.ard = '0;
			endcase
		end
		if (i_avs_write && !q.aw) begin
			case (i_avs_address)
			R_CTRL: begin
				if (i_avs_byteenable[0]) begin
					n.pix16 = wd[C_PIX16];
					if (wd[C_START] && q.st == S_IDLE) begin
						n.pc = q.lbase;
						n.busy = 1'b1;
						n.st = S_FETCH;
					end
				end
			end
			R_STATUS: begin
				if (i_avs_byteenable[0] && wd[ST_DONE]) begin
					n.sdone = 1'b0;
				end
				if (i_avs_byteenable[0] && wd[ST_ERR]) begin
					n.serr = 1'b0;
				end
			end
			R_LBASE: n.lbase = AW'(merge(32'(q.lbase), wd, i_avs_byteenable));
			R_SBASE: n.sbase = AW'(merge(32'(q.sbase), wd, i_avs_byteenable));
			R_PITCH: n.pitch = 16'(merge(32'(q.pitch), wd, i_avs_byteenable));
			R_COLOR: n.color = 16'(merge(32'(q.color), wd, i_avs_byteenable));
			default: n.ard = q.ard;
			endcase
		end

		case (q.st)
		S_IDLE: n.go = 1'b0;
		S_FETCH: begin
			if (!q.mrd) begin
				n.mrd = 1'b1;
				n.maddr = q.pc;
			end else if (i_mem_ack) begin
				n.mrd = 1'b0;
				n.cmd = i_mem_rdata;
				n.cpc = q.pc;
				n.pc = q.pc + AW'(WORD_BYTES);
				n.ac = '0;
				n.st = nargs_f(i_mem_rdata[CODE_LSB +: CODE_W]) == 4'h0 ? S_EXEC : S_ARG;
			end
		end
		S_ARG: begin
			if (!q.mrd) begin
				n.mrd = 1'b1;
				n.maddr = q.pc;
			end else if (i_mem_ack) begin
				n.mrd = 1'b0;
				n.arg[q.ac] = i_mem_rdata;
				n.ac = q.ac + 4'h1;
				n.pc = q.pc + AW'(WORD_BYTES);
				if (q.ac == nargs_f(op) - 4'h1) begin
					n.st = S_EXEC;
				end
			end
		end
		S_EXEC: begin
			n.st = S_FETCH;
			case (op)
			OP_QUAD_MV: begin
				// Linear source uses its own address, else the source plane
				n.base = q.cmd[F_LNI] ? ltgt : q.sbase + poffb[AW-1:0];
				n.stride = q.cmd[F_LNI] ? q.arg[A_W] : q.pitch;
				n.du = '0;
				n.dv = '0;
				n.su = '0;
				n.sv = '0;
				n.k = '0;
				n.ph = PH_LEFT;
				n.go = !direct;
				n.st = direct ? S_SRC : S_LERP;
			end
			OP_JUMP: n.pc = lin[AW-1:0];
			OP_LIST_SUBROUTINE_CALL: begin
				n.rpc = q.pc;
				n.pc = lin[AW-1:0];
			end
			OP_RET: n.pc = q.rpc;
			OP_NOP: n.st = S_FETCH;
			OP_FSYNC: n.st = S_FSYNC;
			OP_END: begin
				n.ldone = 1'b1;
				n.sdone = 1'b1;
				n.busy = 1'b0;
				n.st = S_IDLE;
			end
			OP_REGW: begin
				n.rw = 1'b1;
				n.rwa = q.arg[A_HI];
				n.rwd = q.arg[A_LO];
			end
			OP_WCLR: n.wclr = 1'b1;
			default: begin
				// Unsupported code: stop rather than run off into data
				n.serr = 1'b1;
				n.busy = 1'b0;
				n.st = S_IDLE;
			end
			endcase
		end
		S_FSYNC: begin
			if (i_frame_tick) begin
				n.st = S_FETCH;
			end
		end
		S_LERP: begin
			if (done_x) begin
				case (q.ph)
				PH_LEFT: begin
					n.lx = res_x;
					n.ly = res_y;
					n.ph = PH_RIGHT;
					n.go = 1'b1;
				end
				PH_RIGHT: begin
					n.rx = res_x;
					n.ry = res_y;
					n.ph = PH_POINT;
					n.go = 1'b1;
				end
				default: begin
					n.px = res_x;
					n.py = res_y;
					n.st = S_SRC;
				end
				endcase
			end
		end
		S_SRC: begin
			if (!q.mrd) begin
				n.mrd = 1'b1;
				n.maddr = {saddr[AW-1:1], 1'b0};
			end else if (i_mem_ack) begin
				n.mrd = 1'b0;
				n.pix[q.k*LANE_W +: LANE_W] = lane;
				if (fast_quad_sel && q.k != LANE_LAST) begin
					n.k = q.k + 2'h1;
				end else begin
					n.k = '0;
					if (direct) begin
						n.px = q.arg[A_VX1] + q.du;
						n.py = q.arg[A_VY1] + q.dv;
					end
					n.st = q.cmd[F_WORK] ? S_WORK : S_PIX;
				end
			end
		end
		S_WORK: begin
			if (!q.wrd) begin
				n.wrd = 1'b1;
			end else if (i_wk_ack) begin
				n.wrd = 1'b0;
				n.st = i_wk_bit ? S_PIX : S_NEXT;
			end
		end
		S_PIX: begin
			if (!q.pwr) begin
				n.pwr = 1'b1;
			end else if (i_pix_ack) begin
				n.pwr = 1'b0;
				n.st = S_NEXT;
			end
		end
		S_NEXT: begin
			n.go = !direct;
			n.st = direct ? S_SRC : S_LERP;
			if (du_n >= cols) begin
				n.du = '0;
				n.su = '0;
				n.dv = dv_n;
				n.sv = sv_n >= q.arg[A_H] ? '0 : sv_n;
				n.ph = PH_LEFT;
				if (dv_n >= rows) begin
					n.go = 1'b0;
					n.st = S_FETCH;
				end
			end else begin
				n.du = du_n;
				n.su = su_n >= q.arg[A_W] ? '0 : su_n;
				n.ph = PH_POINT;
			end
		end
		default: n.st = S_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
			q.aw <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// ---------------------------------------------------------------
	// Shared arithmetic
	// ---------------------------------------------------------------
	// Both axes take the same number of cycles, so x done covers y
	quad_lerp #(.W(16)) u_lerp_x (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_start(q.go),
		.i_a(la_x),
		.i_b(lb_x),
		.i_n(l_n),
		.i_d(l_d),
		.o_done(done_x),
		.o_res(res_x)
	);

	quad_lerp #(.W(16)) u_lerp_y (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_start(q.go),
		.i_a(la_y),
		.i_b(lb_y),
		.i_n(l_n),
		.i_d(l_d),
		.o_done(),
		.o_res(res_y)
	);

	quad_sat #(.W(16)) u_sat (
		.i_a(i_mem_rdata),
		.i_b(q.color),
		.o_sum(sat_sum)
	);

	assign o_avs_readdata = q.ard;
	assign o_avs_waitrequest = q.aw;
	assign o_mem_rd = q.mrd;
	assign o_mem_addr = q.maddr;
	assign o_wk_rd = q.wrd;
	assign o_pix_wr = q.pwr;
	assign o_pix_x = q.px;
	assign o_pix_y = q.py;
	assign o_pix_data = q.pix;
	assign o_pix_quad = q.cmd[F_FST];
	assign o_pix_clipping_sel = q.cmd[F_CLIPPING_SEL];
	assign o_busy = q.busy;
	assign o_list_done = q.ldone;
	assign o_regw_en = q.rw;
	assign o_regw_addr = q.rwa;
	assign o_regw_data = q.rwd;
	assign o_work_clr = q.wclr;
endmodule

// ===== quad_list_engine_bench.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
	$display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module quad_list_engine_bench;
	import quad_pkg::*;
	logic mclk, rst_b, rd, wr, waitreq, tick, busy, done, regw_en, wclr, clipping_sel;
	logic mem_rd, mem_ack, wk_rd, wk_ack, wk_bit, pix_wr, pix_quad, pix_ack;
	logic [4:0] adr;
	logic [31:0] wd, rdat;
	logic [23:0] mem_addr;
	logic [15:0] mem_rdata, pix_x, pix_y, regw_addr, regw_data;
	logic [63:0] pix_data, e64;
	logic [16:0] sum;
	int miscompares, n_compared, n_done, n_regw, n_wclr, n_clipping_sel;

	quad_list_engine i_quad_list_engine (.i_mclk(mclk), .i_rst_b(rst_b), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(waitreq), .o_mem_rd(mem_rd),
		.o_mem_addr(mem_addr), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_wk_rd(wk_rd),
		.i_wk_ack(wk_ack), .i_wk_bit(wk_bit), .o_pix_wr(pix_wr), .o_pix_x(pix_x),
		.o_pix_y(pix_y), .o_pix_data(pix_data), .o_pix_quad(pix_quad), .o_pix_clipping_sel(clipping_sel),
		.i_pix_ack(pix_ack), .i_frame_tick(tick), .o_busy(busy), .o_list_done(done),
		.o_regw_en(regw_en), .o_regw_addr(regw_addr), .o_regw_data(regw_data),
		.o_work_clr(wclr));
	quad_mem_model i_quad_mem_model (.i_mclk(mclk), .i_rst_b(rst_b), .i_mem_rd(mem_rd),
		.i_mem_addr(mem_addr), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata), .i_wk_rd(wk_rd),
		.o_wk_ack(wk_ack), .o_wk_bit(wk_bit), .i_pix_wr(pix_wr), .i_pix_x(pix_x),
		.i_pix_y(pix_y), .i_pix_data(pix_data), .i_pix_quad(pix_quad), .o_pix_ack(pix_ack));

	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		n_done += int'(done === 1'b1);
		n_regw += int'(regw_en === 1'b1);
		n_wclr += int'(wclr === 1'b1);
		n_clipping_sel += int'(pix_wr === 1'b1 && pix_ack === 1'b1 && clipping_sel === 1'b1);
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		do @(posedge mclk); while (waitreq !== 1'b0);
		wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		adr <= a;
		rd <= 1'b1;
		do @(posedge mclk); while (waitreq !== 1'b0);
		`CHK(rdat, e)
		rd <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic load(input int a, input logic [15:0] w [$]);
		foreach (w[i]) i_quad_mem_model.mem[a / 2 + i] = w[i];
	endtask
	task automatic give_verdict();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		give_verdict();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{mclk, rst_b, rd, wr, tick} = 5'h00;
		adr = 5'h00;
		wd = 32'h0;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		rd_chk(R_STATUS, 32'h0);
		rd_chk(R_CTRL, 32'h0);
		av_wr(R_COLOR, 32'h0000fef8);
		rd_chk(R_COLOR, 32'h0000fef8);
		av_wr(5'h1c, 32'hffffffff);
		rd_chk(5'h1c, 32'h0);
		// Jump over bad codes, then nop, register write, clear, call, sync, end
		load(0, '{16'h8000, 16'h0000, 16'h0010, 16'hf800, 16'hf800, 16'hf800, 16'hf800,
			16'hf800, 16'h9800, 16'hb000, 16'h0040, 16'h1234, 16'hb800, 16'h8800, 16'h0000,
			16'h0040, 16'ha000, 16'ha800});
		// Relative repeat draw with work and offset, 8 px wide source
		load('h40, '{16'h0147, 16'h0000, 16'h00c0, 16'h0008, 16'h0001, 16'h0000, 16'h0000,
			16'h0009, 16'h0000, 16'h0009, 16'h0000, 16'h0000, 16'h0000});
		// Fast clipped aligned 32 px rectangle from absolute linear source, then return
		load('h5a, '{16'h008c, 16'h0000, 16'h0100, 16'h0020, 16'h0001, 16'h0008, 16'h0005,
			16'h0027, 16'h0005, 16'h0027, 16'h0005, 16'h0008, 16'h0005, 16'h9000});
		av_wr(R_LBASE, 32'h0);
		av_wr(R_CTRL, 32'h3);
		// Long enough for both draws; the list must then sit at the sync
		repeat (3000) @(posedge mclk);
		`CHK(n_done, 0)
		`CHK(busy, 1'b1)
		tick <= 1'b1;
		@(posedge mclk);
		tick <= 1'b0;
		for (int i = 0; i < 200 && n_done == 0; i++) @(posedge mclk);
		`CHK(n_done, 1)
		`CHK(n_regw, 1)
		`CHK(regw_addr, 16'h0040)
		`CHK(regw_data, 16'h1234)
		`CHK(n_wclr, 1)
		`CHK(i_quad_mem_model.n_wr, 13)
		for (int k = 0; k < 5; k++) begin
			sum = 17'h00100 + 17'((4 * k) % 16) + 17'h0fef8;
			`CHK(i_quad_mem_model.wr_x[k], 16'(2 * k))
			`CHK(i_quad_mem_model.wr_d[k][15:0], sum[16] ? 16'hffff : sum[15:0])
			`CHK(i_quad_mem_model.wr_q[k], 1'b0)
		end
		for (int k = 0; k < 8; k++) begin
			for (int j = 0; j < 4; j++) e64[16 * j +: 16] = 16'h0100 + 16'(8 * k + 2 * j);
			`CHK(i_quad_mem_model.wr_x[5 + k], 16'(8 + 4 * k))
			`CHK(i_quad_mem_model.wr_y[5 + k], 16'h0005)
			`CHK(i_quad_mem_model.wr_d[5 + k], e64)
			`CHK(i_quad_mem_model.wr_q[5 + k], 1'b1)
		end
		rd_chk(R_STATUS, 32'h2);
		av_wr(R_STATUS, 32'h2);
		rd_chk(R_STATUS, 32'h0);
		// Unknown code stops the list with an error
		load('h80, '{16'hf800});
		av_wr(R_LBASE, 32'h80);
		av_wr(R_CTRL, 32'h1);
		repeat (100) @(posedge mclk);
		rd_chk(R_STATUS, 32'h4);
		rd_chk(R_CTRL, 32'h0);
		// Pixel-mode 8 bpp source, edges and points interpolated
		load('ha0, '{16'h0000, 16'h0002, 16'h0001, 16'h0008, 16'h0001, 16'h0000, 16'h0003,
			16'h000e, 16'h0003, 16'h000e, 16'h0003, 16'h0000, 16'h0003, 16'ha800});
		av_wr(R_SBASE, 32'h100);
		av_wr(R_PITCH, 32'h10);
		av_wr(R_LBASE, 32'ha0);
		av_wr(R_CTRL, 32'h1);
		for (int i = 0; i < 2000 && n_done < 2; i++) @(posedge mclk);
		`CHK(n_done, 2)
		`CHK(n_clipping_sel, 8)
		`CHK(i_quad_mem_model.n_wr, 21)
		for (int k = 0; k < 3; k++) begin
			`CHK(i_quad_mem_model.wr_x[13 + k], 16'(2 * k))
			`CHK(i_quad_mem_model.wr_y[13 + k], 16'h0003)
			`CHK(i_quad_mem_model.wr_d[13 + k][15:0], (k % 2) ? 16'h0001 : 16'(18 + k))
		end
		rd_chk(R_PC, 32'hbc);
		give_verdict();
	end
endmodule

// ===== quad_list_engine_checker.sv
`timescale 1ns/100ps
module quad_list_engine_checker #(
	parameter int AW = 24
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Memory read
	input wire logic o_mem_rd,
	input wire logic [AW-1:0] o_mem_addr,
	input wire logic i_mem_ack,
	// Work read and pixel write
	input wire logic o_wk_rd,
	input wire logic i_wk_ack,
	input wire logic i_wk_bit,
	input wire logic o_pix_wr,
	input wire logic [15:0] o_pix_x,
	input wire logic [15:0] o_pix_y,
	input wire logic [63:0] o_pix_data,
	input wire logic i_pix_ack,
	// Controller side
	input wire logic o_busy,
	input wire logic o_list_done,
	input wire logic o_regw_en,
	input wire logic [15:0] o_regw_addr,
	input wire logic [15:0] o_regw_data,
	input wire logic o_work_clr
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	a_mem_even: assert property (o_mem_rd |-> !o_mem_addr[0])
		else $error("odd memory address");
	a_mem_held: assert property (o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_addr))
		else $error("read request dropped early");
	a_mem_release: assert property (i_mem_ack |=> !o_mem_rd)
		else $error("read held after ack");
	a_done_pulse: assert property (o_list_done |=> !o_list_done)
		else $error("done not a pulse");
	a_end_quiet: assert property (o_list_done |=> !o_mem_rd [*3])
		else $error("fetch after end");
	a_idle_quiet: assert property (!o_busy |-> !o_mem_rd && !o_pix_wr && !o_wk_rd)
		else $error("traffic while idle");
	a_pix_held: assert property (o_pix_wr && !i_pix_ack |=>
		o_pix_wr && $stable(o_pix_x) && $stable(o_pix_y) && $stable(o_pix_data))
		else $error("pixel write not held");
	a_work_held: assert property (o_wk_rd && !i_wk_ack |=> o_wk_rd && $stable(o_pix_x))
		else $error("work read not held");
	a_work_skip: assert property (i_wk_ack && !i_wk_bit |=> !o_pix_wr [*2])
		else $error("write despite work zero");
	a_regw_pulse: assert property (o_regw_en |=> !o_regw_en)
		else $error("register write not a pulse");
	a_regw_hold: assert property (!o_regw_en |-> $stable(o_regw_addr) && $stable(o_regw_data))
		else $error("register write value moved");
	a_clear_pulse: assert property (o_work_clr |=> !o_work_clr)
		else $error("work clear not a pulse");
endmodule

bind quad_list_engine quad_list_engine_checker #(.AW(AW)) i_quad_list_engine_checker (
	.i_mclk, .i_rst_b, .o_mem_rd, .o_mem_addr, .i_mem_ack, .o_wk_rd, .i_wk_ack, .i_wk_bit,
	.o_pix_wr, .o_pix_x, .o_pix_y, .o_pix_data, .i_pix_ack, .o_busy, .o_list_done,
	.o_regw_en, .o_regw_addr, .o_regw_data, .o_work_clr);

// ===== quad_mem_model.sv
`timescale 1ns/100ps
module quad_mem_model (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// List and source read
	input wire logic i_mem_rd,
	input wire logic [23:0] i_mem_addr,
	output logic o_mem_ack,
	output logic [15:0] o_mem_rdata,
	// Work plane and pixel write
	input wire logic i_wk_rd,
	output logic o_wk_ack,
	output logic o_wk_bit,
	input wire logic i_pix_wr,
	input wire logic [15:0] i_pix_x,
	input wire logic [15:0] i_pix_y,
	input wire logic [63:0] i_pix_data,
	input wire logic i_pix_quad,
	output logic o_pix_ack
);
	logic [15:0] mem [0:255];
	logic [15:0] wr_x [0:15];
	logic [15:0] wr_y [0:15];
	logic [63:0] wr_d [0:15];
	logic wr_q [0:15];
	int n_wr;
	logic [1:0] cnt;
	logic slow;
	// Each word holds its own byte address
	initial for (int i = 0; i < 256; i++) mem[i] = 16'(2 * i);
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{o_mem_ack, o_wk_ack, o_pix_ack, o_wk_bit, slow} <= 5'h00;
			o_mem_rdata <= 16'h0000;
			cnt <= 2'h0;
			n_wr <= 0;
		end else begin
			{o_mem_ack, o_wk_ack, o_pix_ack} <= 3'h0;
			// Released lines keep changing so stale data cannot pass
			o_mem_rdata <= ~o_mem_rdata;
			o_wk_bit <= ~o_wk_bit;
			if ((i_mem_rd || i_wk_rd || i_pix_wr) && !(o_mem_ack || o_wk_ack || o_pix_ack)) begin
				// Alternate prompt and slow answers
				if (cnt != (slow ? 2'h3 : 2'h0)) begin
					cnt <= cnt + 2'h1;
				end else begin
					cnt <= 2'h0;
					slow <= ~slow;
					if (i_mem_rd) begin
						o_mem_ack <= 1'b1;
						o_mem_rdata <= mem[i_mem_addr[8:1]];
					end else if (i_wk_rd) begin
						o_wk_ack <= 1'b1;
						o_wk_bit <= ~i_pix_x[0];
					end else begin
						o_pix_ack <= 1'b1;
						if (n_wr < 16) begin
							wr_x[n_wr] <= i_pix_x;
							wr_y[n_wr] <= i_pix_y;
							wr_d[n_wr] <= i_pix_data;
							wr_q[n_wr] <= i_pix_quad;
						end
						n_wr <= n_wr + 1;
					end
				end
			end
		end
	end
endmodule

// ===== quad_pkg.sv
package quad_pkg;
	// ---------------------------------------------------------------
	// Command word layout
	// ---------------------------------------------------------------
	localparam int CODE_LSB = 11;
	localparam int CODE_W = 5;
	localparam int F_TRANSPARENCY_SEL = 9;
	localparam int F_REPEAT_SOURCE_SEL = 8;
	localparam int F_CLIPPING_SEL = 7;
	localparam int F_REL = 6;
	localparam int F_FST = 3;
	localparam int F_LNI = 2;
	localparam int F_COLOR_OFFSET_SEL = 1;
	localparam int F_WORK = 0;

	// ---------------------------------------------------------------
	// Command codes
	// ---------------------------------------------------------------
	localparam logic [4:0] OP_QUAD_MV = 5'h00;
	localparam logic [4:0] OP_JUMP = 5'h10;
	localparam logic [4:0] OP_LIST_SUBROUTINE_CALL = 5'h11;
	localparam logic [4:0] OP_RET = 5'h12;
	localparam logic [4:0] OP_NOP = 5'h13;
	localparam logic [4:0] OP_FSYNC = 5'h14;
	localparam logic [4:0] OP_END = 5'h15;
	localparam logic [4:0] OP_REGW = 5'h16;
	localparam logic [4:0] OP_WCLR = 5'h17;

	// ---------------------------------------------------------------
	// Parameter words following the code word
	// ---------------------------------------------------------------
	localparam int NARG = 12;
	localparam logic [3:0] NARG_QUAD = 4'hc;
	localparam logic [3:0] NARG_PAIR = 4'h2;
	localparam int A_HI = 0;
	localparam int A_LO = 1;
	localparam int A_SX = 0;
	localparam int A_SY = 1;
	localparam int A_W = 2;
	localparam int A_H = 3;
	localparam int A_VX1 = 4;
	localparam int A_VY1 = 5;
	localparam int A_VX2 = 6;
	localparam int A_VY2 = 7;
	localparam int A_VX3 = 8;
	localparam int A_VY3 = 9;
	localparam int A_VX4 = 10;
	localparam int A_VY4 = 11;
	localparam int WORD_BYTES = 2;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int RA_W = 5;
	localparam logic [4:0] R_CTRL = 5'h00;
	localparam logic [4:0] R_STATUS = 5'h04;
	localparam logic [4:0] R_LBASE = 5'h08;
	localparam logic [4:0] R_SBASE = 5'h0c;
	localparam logic [4:0] R_PITCH = 5'h10;
	localparam logic [4:0] R_COLOR = 5'h14;
	localparam logic [4:0] R_PC = 5'h18;
	localparam int C_START = 0;
	localparam int C_PIX16 = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;

	// ---------------------------------------------------------------
	// Drawing
	// ---------------------------------------------------------------
	localparam int LANE_W = 16;
	localparam logic [15:0] STEP_ONE = 16'h0001;
	localparam logic [15:0] STEP_FAST = 16'h0004;
	localparam logic [1:0] LANE_LAST = 2'h3;
	localparam logic [1:0] PH_LEFT = 2'h0;
	localparam logic [1:0] PH_RIGHT = 2'h1;
	localparam logic [1:0] PH_POINT = 2'h2;

	typedef enum logic [3:0] {
		S_IDLE, S_FETCH, S_ARG, S_EXEC, S_FSYNC, S_LERP, S_SRC, S_WORK, S_PIX, S_NEXT
	} state_e;

	function automatic logic [3:0] nargs_f(input logic [4:0] op);
		case (op)
		OP_QUAD_MV: nargs_f = NARG_QUAD;
		OP_JUMP, OP_LIST_SUBROUTINE_CALL, OP_REGW: nargs_f = NARG_PAIR;
		default: nargs_f = 4'h0;
		endcase
	endfunction
endpackage

// ===== quad_sat.sv
`timescale 1ns/100ps
module quad_sat #(
	parameter int W = 16
) (
	// Operands
	input wire logic [W-1:0] i_a,
	input wire logic [W-1:0] i_b,
	// Clamped sum
	output logic [W-1:0] o_sum
);
	logic [W:0] s;

	if (W < 1) begin : g_chk
		$error("quad_sat: W must be positive");
	end

	assign s = {1'b0, i_a} + {1'b0, i_b};
	// Clamp at all ones instead of wrapping
	assign o_sum = s[W] ? {W{1'b1}} : s[W-1:0];
endmodule
